// ==== rtl/uic_ctrl.sv ====
// Serial controller: interrupts, receiver, receive and transmit FIFOs.
`timescale 1ns/1ns
`default_nettype none
`include "uic_defs.svh"
//
// Function
// R1 - Rank causes: line status, data or timeout, holding empty, modem status.
// R2 - Ident bit 0 reads low while an enabled cause pends, else high.
// R3 - Ident reports only top cause: 06, 04, 02, 00.
// R4 - Ident bit 3 joins bit 2 for FIFO timeout; zero otherwise.
// R5 - Ident bits 4,5 read zero; bits 6,7 follow FIFO enable.
// R6 - Enable bits gate data/timeout, holding empty, line status, modem; 4-7 zero.
// R7 - No enables: no ident, interrupt low; status still updates.
// R8 - Start edge from idle, count 16x clock to centre, recheck low.
// R9 - Character length, parity enable and parity sense from line control.
// R10 - Data ready set on full character, cleared by buffer read.
// R11 - Overrun, parity and framing error status bits.
// R12 - Reset reinits counters, clears line status but sets both empty flags, clears modem control.
// R13 - Reset leaves line control, divisors, receive and holding data alone.
// R14 - Holding empty interrupt appears once enabled after reset.
// R15 - Software writes enables last and reconfigures only when idle.
// R16 - FIFO mode: data ready while the receive FIFO is not empty.
// R17 - FIFO mode: data interrupt while fill is at or above trigger.
// R18 - Timeout after four idle character times with data held.
// R19 - Timeout timer restarts on read or new character; read clears timeout.
// R20 - FIFO mode: holding empty delayed unless two bytes queued; immediate on FIFO enable.
// R21 - Holding empty interrupt cleared by data write or ident read.
// R22 - Interrupts off with FIFOs on: polled, FIFOs still store.
// R23 - Trigger codes 00..11 select 1, 4, 8, 14 bytes.
// R24 - Modem deltas set on input change, cleared by status read; the code sets bit 2 only when its status bit rises.
// R25 - Line status interrupt from errors, cleared by line status read.
module uic_ctrl
  import uic_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       serial_input,
  output logic            serial_output,
  input  wire logic [3:0] modem_in_n,
  output logic      [3:0] modem_ctl_n,
  output logic            intr
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  generate
    if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("DEPTH must be a power of two of at least 16");
    end
  endgenerate

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic [7:0] line_control_reg, interrupt_enable, dll, divisor_high_latch;
  logic [4:0] modem_control_reg;
  logic       fifo_en;
  logic [1:0] trig_sel;
  wire        dlab   = line_control_reg[`UIC_LCR_DLAB];
  wire        wr_thr = wr && addr == `UIC_OFF_DATA && !dlab;
  wire        wr_dll = wr && addr == `UIC_OFF_DATA && dlab;
  wire        wr_dlm = wr && addr == `UIC_OFF_IER && dlab;
  wire        wr_ier = wr && addr == `UIC_OFF_IER && !dlab;
  wire        wr_fcr = wr && addr == `UIC_OFF_IIR;
  wire        rd_rbr = rd && addr == `UIC_OFF_DATA && !dlab;
  wire        rd_iir = rd && addr == `UIC_OFF_IIR;
  wire        rd_lsr = rd && addr == `UIC_OFF_LSR;
  wire        rd_msr = rd && addr == `UIC_OFF_MSR;
  wire        fifo_on  = wr_fcr && wdata[0] && !fifo_en;
  wire        rx_clr = wr_fcr && (wdata[0] != fifo_en || (wdata[0] && wdata[1]));
  wire        tx_clr = wr_fcr && (wdata[0] != fifo_en || (wdata[0] && wdata[2]));
  wire        loop   = modem_control_reg[`UIC_MCR_LOOP];

  // Line control and divisors; data and format registers ignore reset. see R13
  always_ff @(posedge clk) begin
    if (wr && addr == `UIC_OFF_LCR)
      line_control_reg <= wdata;
    if (wr_dll)
      dll <= wdata;
    if (wr_dlm)
      divisor_high_latch <= wdata;
  end

  // Only the low nibble of the enables is storage. see R6
  always_ff @(posedge clk) begin
    if (srst) begin
      interrupt_enable      <= `UIC_RST_IER;
      modem_control_reg      <= `UIC_RST_MCR; // see R12
      fifo_en  <= 1'b0;
      trig_sel <= 2'h0;
    end else begin
      if (wr_ier)
        interrupt_enable <= {4'h0, wdata[3:0]};
      if (wr && addr == `UIC_OFF_MCR)
        modem_control_reg <= wdata[4:0];
      if (wr_fcr)
        fifo_en <= wdata[0];
      if (wr_fcr && wdata[0])
        trig_sel <= wdata[7:6];
    end
  end

  // ----------------------------------------
  // Character format
  // ----------------------------------------
  wire [3:0] wl     = 4'h5 + {2'h0, line_control_reg[1:0]}; // see R9
  wire       pen    = line_control_reg[`UIC_LCR_PEN];
  wire [3:0] stopn  = line_control_reg[`UIC_LCR_STB] ? 4'h2 : 4'h1;
  wire [3:0] rx_bits = wl + {3'h0, pen} + 4'h1;
  wire [3:0] frame  = rx_bits + stopn;
  wire [7:0] wl_mask = 8'hff >> (2'h3 - line_control_reg[1:0]);

  // ----------------------------------------
  // Baud generator, one 16x tick per divisor
  // ----------------------------------------
  logic [15:0] baud_cnt;
  wire  [15:0] divisor = {divisor_high_latch, dll};
  wire         tick = baud_cnt >= divisor - 16'h1;

  // Loading a divisor restarts the count so no long first period. see R12
  always_ff @(posedge clk) begin
    if (srst || wr_dll || wr_dlm || tick)
      baud_cnt <= 16'h0;
    else
      baud_cnt <= baud_cnt + 16'h1;
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  logic          rx_s1, rx_s2, rx_prev, tx_line;
  logic [9:0]    rx_sh;
  logic [3:0]    rx_tk, rx_n;
  uic_rx_state_t rx_state;
  wire           rx_line = loop ? tx_line : rx_s2;

  // Two-stage synchroniser; the edge detect looks only at stage two.
  always_ff @(posedge clk) begin
    rx_s1 <= serial_input;
    rx_s2 <= rx_s1;
    rx_prev <= srst ? 1'b1 : rx_line;
  end

  // Start is accepted only if still low at the centre. see R8
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_state <= UIC_RX_IDLE;
      rx_tk    <= 4'h0;
      rx_n     <= 4'h0;
      rx_sh    <= 10'h0;
    end else begin
      unique case (rx_state)
        UIC_RX_IDLE: if (rx_prev && !rx_line) begin
          rx_state <= UIC_RX_START;
          rx_tk    <= 4'h0;
        end
        UIC_RX_START: if (tick) begin
          rx_tk <= rx_tk + 4'h1;
          if (rx_tk == `UIC_START_TKS - 4'h1) begin
            rx_state <= rx_line ? UIC_RX_IDLE : UIC_RX_BITS; // see R8
            rx_tk    <= 4'h0;
            rx_n     <= 4'h0;
          end
        end
        UIC_RX_BITS: if (tick) begin
          rx_tk <= rx_tk + 4'h1;
          if (rx_tk == `UIC_BIT_TKS) begin
            rx_sh <= {rx_line, rx_sh[9:1]};
            rx_n  <= rx_n + 4'h1;
            if (rx_n == rx_bits - 4'h1)
              rx_state <= UIC_RX_IDLE;
          end
        end
      endcase
    end
  end

  // Frame check on the last sample, without waiting a cycle.
  wire rx_push = rx_state == UIC_RX_BITS && tick && rx_tk == `UIC_BIT_TKS
                 && rx_n == rx_bits - 4'h1;
  wire [9:0] rx_word = {rx_line, rx_sh[9:1]} >> (4'ha - rx_bits);
  wire [7:0] rx_data = rx_word[7:0] & wl_mask;
  wire       rx_par  = ^rx_data ^ rx_word[wl];
  uic_rx_entry_t rx_new;
  assign rx_new.data = rx_data;
  assign rx_new.pe   = pen && rx_par == line_control_reg[`UIC_LCR_EPS]; // see R9
  assign rx_new.fe   = !rx_word[rx_bits - 4'h1];
  assign rx_new.bi   = rx_word == 10'h0;

  // ----------------------------------------
  // Receive FIFO; depth one outside FIFO mode
  // ----------------------------------------
  uic_rx_entry_t rx_mem [DEPTH];
  logic [AW-1:0] rx_wp, rx_rp;
  logic [CW-1:0] rx_count;
  wire rx_pop  = rd_rbr && rx_count != '0;
  wire rx_full = fifo_en ? rx_count == CW'(DEPTH) : rx_count != '0;
  wire rx_ovr  = rx_push && rx_full && !rx_pop;
  wire rx_wr   = rx_push && !rx_ovr;
  wire [4:0] trig = trig_sel == 2'h0 ? `UIC_TRIG_0 : trig_sel == 2'h1 ? `UIC_TRIG_1 :
                    trig_sel == 2'h2 ? `UIC_TRIG_2 : `UIC_TRIG_3; // see R23

  // Without FIFOs a new character overwrites the unread one. see R11
  always_ff @(posedge clk) begin
    if (rx_wr)
      rx_mem[rx_wp] <= rx_new;
    else if (rx_ovr && !fifo_en)
      rx_mem[rx_rp] <= rx_new;
  end

  // Storage continues whatever the enables say. see R22
  always_ff @(posedge clk) begin
    if (srst || rx_clr) begin
      rx_wp    <= '0;
      rx_rp    <= '0;
      rx_count <= '0;
    end else begin
      if (rx_wr)
        rx_wp <= rx_wp + AW'(1);
      if (rx_pop)
        rx_rp <= rx_rp + AW'(1);
      rx_count <= rx_count + CW'(rx_wr) - CW'(rx_pop);
    end
  end

  // ----------------------------------------
  // Line status flags, set wins over clear
  // ----------------------------------------
  logic oe, pe, fe, bi;
  wire  err_new = rx_push && (rx_new.pe || rx_new.fe || rx_new.bi);

  always_ff @(posedge clk) begin
    if (srst) begin
      {oe, pe, fe, bi} <= 4'h0; // see R12
    end else begin
      oe <= rx_ovr || (oe && !rd_lsr);             // see R11
      pe <= (rx_push && rx_new.pe) || (pe && !rd_lsr); // see R11
      fe <= (rx_push && rx_new.fe) || (fe && !rd_lsr); // see R11
      bi <= (err_new && rx_new.bi) || (bi && !rd_lsr);
    end
  end

  // ----------------------------------------
  // Character timeout
  // ----------------------------------------
  logic       to_pend;
  logic [9:0] to_cnt;
  // Frame length times 16 ticks, shifted left by two for four character times.
  wire  [9:0] to_limit = {2'h0, frame, 4'h0} << `UIC_TO_CHARS;
  wire        to_hit = tick && to_cnt == to_limit - 10'h1 && !to_pend;

  // Second stop bit is part of the frame length. see R18
  always_ff @(posedge clk) begin
    if (srst || rx_pop || (rx_push && !to_pend) || rx_count == '0)
      to_cnt <= 10'h0; // see R19
    else if (tick && fifo_en && !to_pend)
      to_cnt <= to_cnt + 10'h1;
  end

  // Pop clears the timeout, but a fresh hit still wins. see R19
  always_ff @(posedge clk) begin
    if (srst)
      to_pend <= 1'b0;
    else
      to_pend <= (to_hit && fifo_en && rx_count != '0) ||
                 (to_pend && !rx_pop && fifo_en); // see R18
  end

  // ----------------------------------------
  // Transmit FIFO and shifter
  // ----------------------------------------
  logic [7:0]    tx_mem [DEPTH];
  logic [AW-1:0] tx_wp, tx_rp;
  logic [CW-1:0] tx_count;
  logic [11:0]   tx_sh;
  logic [3:0]    tx_tk, tx_left;
  logic          tx_busy;
  wire tx_full = fifo_en ? tx_count == CW'(DEPTH) : tx_count != '0;
  wire tx_push = wr_thr && !tx_full;
  wire tx_load = !tx_busy && tx_count != '0;
  wire tx_holding_empty    = tx_count == '0;
  wire tx_all_empty    = tx_holding_empty && !tx_busy;
  wire [7:0]  tx_d   = tx_mem[tx_rp] & wl_mask;
  wire [11:0] tx_par = {11'h0, pen && (^tx_d ^ !line_control_reg[`UIC_LCR_EPS])};
  wire [11:0] tx_frame = (12'hfff << (wl + {3'h0, pen} + 4'h1)) | (tx_par << (wl + 4'h1))
                         | {3'h0, tx_d, 1'b0};

  always_ff @(posedge clk) begin
    if (tx_push)
      tx_mem[tx_wp] <= wdata;
  end

  // Shifter steps one bit per 16 ticks; idle line is marking.
  always_ff @(posedge clk) begin
    if (srst || tx_clr) begin
      tx_wp    <= '0;
      tx_rp    <= '0;
      tx_count <= '0;
    end else begin
      if (tx_push)
        tx_wp <= tx_wp + AW'(1);
      if (tx_load)
        tx_rp <= tx_rp + AW'(1);
      tx_count <= tx_count + CW'(tx_push) - CW'(tx_load);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_busy <= 1'b0; // see R12
      tx_tk   <= 4'h0;
      tx_left <= 4'h0;
      tx_sh   <= 12'hfff;
    end else if (tx_load) begin
      tx_busy <= 1'b1;
      tx_tk   <= 4'h0;
      tx_left <= frame;
      tx_sh   <= tx_frame;
    end else if (tx_busy && tick) begin
      tx_tk <= tx_tk + 4'h1;
      if (tx_tk == `UIC_BIT_TKS) begin
        tx_sh   <= {1'b1, tx_sh[11:1]};
        tx_left <= tx_left - 4'h1;
        tx_busy <= tx_left != 4'h1;
      end
    end
  end

  // Break and loopback act on the pin only.
  always_ff @(posedge clk) begin
    tx_line       <= srst ? 1'b1 : tx_sh[0];
    serial_output <= srst || loop || (tx_sh[0] && !line_control_reg[`UIC_LCR_BREAK]);
  end

  // ----------------------------------------
  // Holding empty interrupt source
  // ----------------------------------------
  logic       tx_holding_empty_prev, two_seen, tx_holding_empty_pend;
  logic [7:0] th_dly;
  wire  tx_holding_empty_rise = tx_holding_empty && !tx_holding_empty_prev;
  wire  th_defer  = fifo_en && !two_seen;
  wire  [7:0] dly_load = {frame - 4'h1, 4'h0};
  wire  tx_holding_empty_set = (tx_holding_empty_rise && !th_defer) || (tick && th_dly == 8'h1) || fifo_on;
  wire  [3:0] id;

  // Short bursts get the empty report one frame less a stop late. see R20
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_holding_empty_prev <= 1'b1;
      two_seen  <= 1'b0;
      th_dly    <= 8'h0;
    end else begin
      tx_holding_empty_prev <= tx_holding_empty;
      two_seen  <= tx_count >= CW'(2) || (two_seen && !tx_holding_empty_rise);
      if (tx_holding_empty_rise && th_defer)
        th_dly <= dly_load; // see R20
      else if (tick && th_dly != 8'h0)
        th_dly <= th_dly - 8'h1;
    end
  end

  // Reset leaves it pending so enabling it fires at once. see R14
  always_ff @(posedge clk) begin
    if (srst)
      tx_holding_empty_pend <= 1'b1;
    else
      tx_holding_empty_pend <= tx_holding_empty_set ||
                   (tx_holding_empty_pend && !wr_thr && !(rd_iir && id == `UIC_ID_TX_HOLDING_EMPTY)); // see R21
  end

  // ----------------------------------------
  // Modem status
  // ----------------------------------------
  logic [3:0] md_s1, md_s2, md_prev, delta;
  wire  [3:0] md_st = loop ? {modem_control_reg[3], modem_control_reg[2], modem_control_reg[0], modem_control_reg[1]} : ~md_s2;
  wire  [3:0] md_chg = {md_st[3] ^ md_prev[3], md_st[2] && !md_prev[2],
                        md_st[1:0] ^ md_prev[1:0]};

  // Deltas set on change (bit 2 only when its status bit rises) and clear on read, set winning. see R24
  always_ff @(posedge clk) begin
    md_s1 <= modem_in_n;
    md_s2 <= md_s1;
    md_prev <= md_st;
    modem_ctl_n <= (srst || loop) ? 4'hf : ~modem_control_reg[3:0]; // see R12
    if (srst)
      delta <= 4'h0;
    else
      delta <= md_chg | (delta & {4{!rd_msr}});
  end

  // ----------------------------------------
  // Interrupt priority and identification
  // ----------------------------------------
  wire ls_int  = interrupt_enable[`UIC_IER_LS] && (oe || pe || fe || bi); // see R25
  wire rda_int = interrupt_enable[`UIC_IER_RDA] &&
                 (fifo_en ? rx_count >= CW'(trig) : rx_count != '0); // see R17
  wire to_int  = interrupt_enable[`UIC_IER_RDA] && to_pend && fifo_en; // see R22, R4
  wire th_int  = interrupt_enable[`UIC_IER_TX_HOLDING_EMPTY] && tx_holding_empty_pend;       // see R6
  wire ms_int  = interrupt_enable[`UIC_IER_MS] && delta != 4'h0;
  wire any_int = ls_int || rda_int || to_int || th_int || ms_int; // see R7
  assign id = ls_int  ? `UIC_ID_LS  : rda_int ? `UIC_ID_RDA :
              to_int  ? `UIC_ID_TO  : th_int  ? `UIC_ID_TX_HOLDING_EMPTY :
              ms_int  ? `UIC_ID_MS  : `UIC_ID_NONE; // see R1, R3, R4
  wire [7:0] interrupt_identification = {fifo_en, fifo_en, 2'h0, id};     // see R2, R5
  wire [7:0] line_status_reg = {fifo_en && (pe || fe || bi), tx_all_empty, tx_holding_empty, bi, fe, pe, oe,
                    rx_count != '0}; // see R10, R16

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  wire [7:0] rd_mux = addr == `UIC_OFF_DATA ? (dlab ? dll : rx_mem[rx_rp].data) :
                      addr == `UIC_OFF_IER  ? (dlab ? divisor_high_latch : interrupt_enable) :
                      addr == `UIC_OFF_IIR  ? interrupt_identification :
                      addr == `UIC_OFF_LCR  ? line_control_reg :
                      addr == `UIC_OFF_MCR  ? {3'h0, modem_control_reg} :
                      addr == `UIC_OFF_LSR  ? line_status_reg :
                      addr == `UIC_OFF_MSR  ? {md_st, delta} : 8'h0;

  always_ff @(posedge clk) begin
    rdata <= (srst || !rd) ? 8'h0 : rd_mux;
    intr  <= !srst && any_int;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_PRIO: assert property (ls_int |-> id == `UIC_ID_LS) // see R1
    else $error("line status not top priority");
  AST_IIR0: assert property (rd_iir |=> rdata[0] == !$past(any_int)) // see R2
    else $error("ident bit 0 wrong");
  AST_RSVD: assert property (rd_iir |=> rdata[5:4] == 2'h0 && rdata[7:6] == {2{fifo_en}}) // see R5
    else $error("ident upper bits wrong");
  AST_TOBIT: assert property (rd_iir && !fifo_en |=> !rdata[3]) // see R4
    else $error("timeout bit outside FIFO mode");
  AST_NOEN: assert property (interrupt_enable[3:0] == 4'h0 [*2] |-> !intr) // see R7
    else $error("interrupt with no enables");
  AST_START: assert property (rx_state == UIC_RX_START && tick && rx_tk == 4'h7 && rx_line
                              |=> rx_state == UIC_RX_IDLE) // see R8
    else $error("false start accepted");
  AST_DR: assert property (rx_push && !rx_full |=> line_status_reg[0]) // see R10
    else $error("data ready not set");
  AST_OVR: assert property (rx_push && rx_full && !rx_pop |=> oe) // see R11
    else $error("overrun missed");
  AST_RST: assert property (@(posedge clk) disable iff (1'b0) srst |=> tx_holding_empty && tx_all_empty && !oe && modem_control_reg == 5'h0) // see R12
    else $error("reset state wrong");
  AST_THRCLR: assert property (wr_thr && !tx_holding_empty_set |=> !tx_holding_empty_pend) // see R21
    else $error("holding empty not cleared");
  AST_TOCLR: assert property (rx_pop && !to_hit |=> !to_pend) // see R19
    else $error("timeout not cleared by read");

  COV_RX: cover property (rx_push ##1 rx_pop);
  COV_TO: cover property (!to_pend ##1 to_pend);
  COV_TRIG: cover property (fifo_en && rda_int && rx_count > CW'(1));
endmodule // uic_ctrl
`default_nettype wire

// ==== common/uic_defs.svh ====
// Offsets, reset values, field positions and timing counts of the serial controller.
`ifndef UIC_DEFS_SVH
`define UIC_DEFS_SVH
`define UIC_OFF_DATA   3'h0
`define UIC_OFF_IER    3'h1
`define UIC_OFF_IIR    3'h2
`define UIC_OFF_LCR    3'h3
`define UIC_OFF_MCR    3'h4
`define UIC_OFF_LSR    3'h5
`define UIC_OFF_MSR    3'h6
`define UIC_OFF_SCR    3'h7
`define UIC_LCR_DLAB   7
`define UIC_LCR_BREAK  6
`define UIC_LCR_EPS    4
`define UIC_LCR_PEN    3
`define UIC_LCR_STB    2
`define UIC_MCR_LOOP   4
`define UIC_IER_RDA    0
`define UIC_IER_TX_HOLDING_EMPTY   1
`define UIC_IER_LS     2
`define UIC_IER_MS     3
`define UIC_RST_IER    8'h00
`define UIC_RST_MCR    5'h00
`define UIC_ID_NONE    4'h1
`define UIC_ID_LS      4'h6
`define UIC_ID_RDA     4'h4
`define UIC_ID_TO      4'hc
`define UIC_ID_TX_HOLDING_EMPTY    4'h2
`define UIC_ID_MS      4'h0
`define UIC_TRIG_0     5'h01
`define UIC_TRIG_1     5'h04
`define UIC_TRIG_2     5'h08
`define UIC_TRIG_3     5'h0e
`define UIC_START_TKS  4'h8
`define UIC_BIT_TKS    4'hf
`define UIC_TO_CHARS   2
`endif

// ==== common/uic_pkg.sv ====
// Types shared by the serial controller.
package uic_pkg;
  typedef enum logic [1:0] {
    UIC_RX_IDLE,
    UIC_RX_START,
    UIC_RX_BITS
  } uic_rx_state_t;
  typedef struct packed {
    logic       bi;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } uic_rx_entry_t;
endpackage

// ==== tb/uic_line_model.sv ====
// Serial line model that sends framed characters into the receive input.
`timescale 1ns/1ns
`default_nettype none
module uic_line_model (
  input  wire logic clk,
  output logic      serial_input
);
  // The line rests at mark between frames, as a pulled-up line does.
  initial serial_input = 1'b1;

  // One bit lasts 16 clocks because the bench runs the divisor at 1.
  task automatic put(input logic b);
    @(posedge clk);
    serial_input <= b;
    repeat (15) @(posedge clk);
  endtask

  // Sends one frame LSB first; parity and stop can be broken on request.
  task automatic send(input logic [7:0] d, input int nb, input bit pen, input bit bad_par, input bit bad_stop);
    logic [7:0] m;
    m = d & ((8'h1 << nb) - 8'h1);
    put(1'b0);
    for (int i = 0; i < nb; i++) put(m[i]);
    if (pen) put(^m ^ bad_par);
    put(~bad_stop);
    @(posedge clk);
    serial_input <= 1'b1;
  endtask

  // A short low pulse that must not be taken for a start bit.
  task automatic glitch;
    @(posedge clk);
    serial_input <= 1'b0;
    repeat (4) @(posedge clk);
    serial_input <= 1'b1;
  endtask
endmodule // uic_line_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the serial controller's interrupt and receive logic.
`timescale 1ns/1ns
`default_nettype none
`include "uic_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
  logic       clk, srst, wr, rd, serial_input, serial_output, intr;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic [3:0] modem_in_n, modem_ctl_n;
  logic [7:0] rxq[$];
  int         num_errors, tests_run, nbits;
  bit         pen;
  int         trig[4] = '{1, 4, 8, 14};

  uic_ctrl #(.DEPTH(16)) DUT (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .serial_input(serial_input), .serial_output(serial_output),
    .modem_in_n(modem_in_n), .modem_ctl_n(modem_ctl_n), .intr(intr)
  );
  uic_line_model line (.clk(clk), .serial_input(serial_input));

  // 20 MHz clock.
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ----------------------------------------
  // Bus tasks and the receive model
  // ----------------------------------------
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  // The queue holds what software should read next from the receive buffer.
  task automatic rx(input logic [7:0] v, input bit bp, input bit bs);
    line.send(v, nbits, pen, bp, bs);
    rxq.push_back(v & ((8'h1 << nbits) - 8'h1));
    repeat (6) @(posedge clk);
  endtask

  task automatic pop_chk;
    logic [7:0] e;
    e = rxq.pop_front();
    chk_reg(`UIC_OFF_DATA, e);
  endtask

  task automatic pulse_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
  endtask

  task automatic stop_test;
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hung handshake must not stall the run; the tests need about 10000 cycles.
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    addr = 3'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0; modem_in_n = 4'hf; srst = 1'b1;
    nbits = 8; pen = 1'b0; num_errors = 0; tests_run = 0;
    void'($urandom(32'h2c1e8876));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    // Line control and divisors are not reset, so set them before anything else.
    wr_reg(`UIC_OFF_LCR, 8'h80);
    wr_reg(`UIC_OFF_DATA, 8'h01);
    wr_reg(`UIC_OFF_IER, 8'h00);
    wr_reg(`UIC_OFF_LCR, 8'h03);
    chk_reg(`UIC_OFF_IIR, 8'h01);
    chk_reg(`UIC_OFF_LSR, 8'h60);
    chk_reg(`UIC_OFF_MCR, 8'h00);
    // Enables are written last; the empty holding register interrupts at once.
    wr_reg(`UIC_OFF_IER, 8'hff);
    chk_reg(`UIC_OFF_IER, 8'h0f);
    `CHK(intr, 1'b1)
    chk_reg(`UIC_OFF_IIR, 8'h02);
    chk_reg(`UIC_OFF_IIR, 8'h01);
    `CHK(intr, 1'b0)
    // Single character, then an overrun, in the unbuffered mode.
    wr_reg(`UIC_OFF_IER, 8'h05);
    rx(8'($urandom_range(255)), 0, 0);
    chk_reg(`UIC_OFF_LSR, 8'h61);
    chk_reg(`UIC_OFF_IIR, 8'h04);
    pop_chk();
    chk_reg(`UIC_OFF_LSR, 8'h60);
    rx(8'($urandom_range(255)), 0, 0);
    rx(8'($urandom_range(255)), 0, 0);
    void'(rxq.pop_front());
    chk_reg(`UIC_OFF_IIR, 8'h06);
    chk_reg(`UIC_OFF_LSR, 8'h63);
    chk_reg(`UIC_OFF_IIR, 8'h04);
    pop_chk();
    // Even parity with a bad parity bit, then a missing stop bit.
    pen = 1'b1;
    wr_reg(`UIC_OFF_LCR, 8'h1b);
    rx(8'($urandom_range(255)), 1, 0);
    chk_reg(`UIC_OFF_LSR, 8'h65);
    pop_chk();
    rx(8'($urandom_range(255)) | 8'h01, 0, 1);
    chk_reg(`UIC_OFF_IIR, 8'h06);
    chk_reg(`UIC_OFF_LSR, 8'h69);
    pop_chk();
    line.glitch();
    repeat (200) @(posedge clk);
    chk_reg(`UIC_OFF_LSR, 8'h60);
    // Reset keeps line control but clears modem control and its pins.
    wr_reg(`UIC_OFF_MCR, 8'h0f);
    @(posedge clk);
    #1 `CHK(modem_ctl_n, 4'h0)
    pulse_reset();
    chk_reg(`UIC_OFF_LCR, 8'h1b);
    chk_reg(`UIC_OFF_MCR, 8'h00);
    `CHK(modem_ctl_n, 4'hf)
    chk_reg(`UIC_OFF_IER, 8'h00);
    // Every character length without parity.
    pen = 1'b0;
    for (int w = 0; w < 4; w++) begin
      nbits = 5 + w;
      wr_reg(`UIC_OFF_LCR, 8'(w));
      rx(8'($urandom_range(255)), 0, 0);
      pop_chk();
    end
    // Buffered mode: each trigger level, then the idle timeout.
    for (int t = 0; t < 4; t++) begin
      wr_reg(`UIC_OFF_IIR, {2'(t), 6'h07});
      wr_reg(`UIC_OFF_IER, 8'h01);
      for (int k = 1; k <= trig[t]; k++) begin
        if (k == trig[t]) chk_reg(`UIC_OFF_IIR, 8'hc1);
        rx(8'($urandom_range(255)), 0, 0);
      end
      chk_reg(`UIC_OFF_IIR, 8'hc4);
      chk_reg(`UIC_OFF_LSR, 8'h61);
      pop_chk();
      chk_reg(`UIC_OFF_IIR, 8'hc1);
      if (t > 0) begin
        repeat (600) @(posedge clk);
        chk_reg(`UIC_OFF_IIR, 8'hc1);
        repeat (100) @(posedge clk);
        chk_reg(`UIC_OFF_IIR, 8'hcc);
        `CHK(intr, 1'b1)
        pop_chk();
        chk_reg(`UIC_OFF_IIR, 8'hc1);
      end
      while (rxq.size() > 0) pop_chk();
      chk_reg(`UIC_OFF_LSR, 8'h60);
    end
    // Polled buffered mode stores data but reports nothing.
    wr_reg(`UIC_OFF_IER, 8'h00);
    rx(8'($urandom_range(255)), 0, 0);
    rx(8'($urandom_range(255)), 0, 0);
    repeat (700) @(posedge clk);
    chk_reg(`UIC_OFF_IIR, 8'hc1);
    `CHK(intr, 1'b0)
    chk_reg(`UIC_OFF_LSR, 8'h61);
    pop_chk();
    pop_chk();
    // A modem input change is the lowest cause and clears on status read.
    wr_reg(`UIC_OFF_IER, 8'h08);
    @(posedge clk);
    modem_in_n <= 4'he;
    repeat (6) @(posedge clk);
    chk_reg(`UIC_OFF_IIR, 8'hc0);
    chk_reg(`UIC_OFF_MSR, 8'h11);
    chk_reg(`UIC_OFF_MSR, 8'h10);
    chk_reg(`UIC_OFF_IIR, 8'hc1);
    // A lone byte clears the holding interrupt, which returns one frame less a stop later.
    wr_reg(`UIC_OFF_IER, 8'h02);
    @(posedge clk);
    #1 `CHK(intr, 1'b1)
    wr_reg(`UIC_OFF_DATA, 8'h00);
    chk_reg(`UIC_OFF_IIR, 8'hc1);
    `CHK(serial_output, 1'b0)
    repeat (60) @(posedge clk);
    chk_reg(`UIC_OFF_IIR, 8'hc1);
    repeat (140) @(posedge clk);
    chk_reg(`UIC_OFF_IIR, 8'hc2);
    `CHK(serial_output, 1'b1)
    stop_test();
  end
endmodule // testbench
`default_nettype wire
